// [cipher_descriptor_decode_regs.vh]
`ifndef CIPHER_DESCRIPTOR_DECODE_REGS_VH
`define CIPHER_DESCRIPTOR_DECODE_REGS_VH

// register byte offsets
`define CDD_REG_CTRL        8'h00
`define CDD_REG_FETCH       8'h04
`define CDD_REG_STATUS      8'h08
`define CDD_REG_MODE        8'h0c
`define CDD_REG_LASTHDR     8'h10
`define CDD_REG_SIDELOAD    8'h14

// control fields
`define CDD_CTRL_CHAIN      0
`define CDD_CTRL_STATIC_SC  1
`define CDD_CTRL_STATIC_BC  2
`define CDD_CTRL_RESET_BC   3
`define CDD_CTRL_RESET_SC   4
`define CDD_CTRL_RESET      32'h0000_0001

// header fields
`define CDD_UNIT_SC         8'h10
`define CDD_UNIT_BC         8'h20
`define CDD_TYPE_COMMON     4'h1
`define CDD_TYPE_SC         4'h5
`define CDD_HDR_SC_KEY      32'h1020_0050
`define CDD_HDR_SC_CTX      32'h1070_0050
`define CDD_HDR_SC_RES      32'h1010_0050
`define CDD_HDR_SC_RES_DUMP 32'h1030_0050
`define CDD_BC_MODE_CHAIN   2
`define CDD_BC_MODE_TRIPLE  1
`define CDD_BC_MODE_ENC     0
`define CDD_SC_CTX_LEN      32'h0000_0103

// descriptor layout
`define CDD_PAIRS           3'd7
`define CDD_WORDS           5'd16

`endif

// [descriptor_word_store.v]
`timescale 1ns/1ps
`default_nettype none

module descriptor_word_store #(
	parameter AW = 4,
	parameter DW = 32
) (
	input  wire          clk_i,   // system clock
	input  wire          we_i,    // write strobe
	input  wire [AW-1:0] waddr_i, // write index
	input  wire [DW-1:0] wdata_i, // write word
	input  wire [AW-1:0] raddr_i, // read index
	output reg  [DW-1:0] rdata_o  // registered read word
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end

endmodule // descriptor_word_store

`default_nettype wire

// [cipher_descriptor_decode.v]
// How it works
// - unit options come from the primary and secondary mode header fields
// - stream-cipher variants are fixed header values, not cryptographic modes
// - 0x10200050: load key, permute, cipher, unload context
// - stream context through IV slots is 259 bytes
// - 0x10700050: no permute, load context via FIFO, cipher, unload
// - 0x10100050: cipher with resident context, no permute, no unload
// - 0x10300050: cipher with resident context, then unload it
// - no standalone unload; unload only after ciphering in same descriptor
// - static stream unit keeps cipher state between packets
// - block-cipher descriptors use type 0001 ordering
// - 0x20500010 selects chained, single-key, encrypt
// - 0x20600010 selects chained, triple, decrypt
// - 0x20100010 / 0x20000010 select codebook single-key encrypt / decrypt
// - 0x20300010 / 0x20200010 select codebook triple encrypt / decrypt
// - static block unit keeps key and context between descriptors
// - static block unit latches its mode at first context load
// - type 0001 is common non-snooping, no public-key or stream unit
`timescale 1ns/1ps
`default_nettype none
`include "cipher_descriptor_decode_regs.vh"

module cipher_descriptor_decode (
	input  wire        clk_i,        // system clock
	input  wire        rst_i,        // synchronous reset, active high
	// wishbone slave
	input  wire        wb_cyc_i,     // cycle
	input  wire        wb_stb_i,     // strobe
	input  wire        wb_we_i,      // write enable
	input  wire [7:0]  wb_adr_i,     // byte address
	input  wire [3:0]  wb_sel_i,     // byte selects
	input  wire [31:0] wb_dat_i,     // write data
	output reg  [31:0] wb_dat_o,     // read data
	output reg         wb_ack_o,     // acknowledge
	output wire        wb_err_o,     // unmapped access
	// descriptor memory read port
	output reg         mem_req_o,    // word read request
	output reg  [31:0] mem_adr_o,    // byte address of word
	input  wire        mem_ack_i,    // read data valid
	input  wire [31:0] mem_dat_i,    // read data
	// transfer command to data mover
	output reg         xfer_valid_o, // transfer command valid
	input  wire        xfer_ready_i, // data mover accepts / is done
	output reg  [2:0]  xfer_slot_o,  // pair index 1..7
	output reg  [31:0] xfer_len_o,   // length in bytes
	output reg  [31:0] xfer_ptr_o,   // memory pointer
	output reg         xfer_unit_o,  // 0 stream unit, 1 block unit
	// unit programming
	output reg  [3:0]  sc_ctl_o,     // permute, ctx in, ctx out, cipher
	output reg  [2:0]  bc_mode_o,    // chained, triple, encrypt
	output reg         bc_key_keep_o,// block unit holds key and context
	output reg         sc_keep_o,    // stream unit holds state
	output reg         bc_rst_o,     // block unit reset pulse
	output reg         sc_rst_o,     // stream unit reset pulse
	output reg         busy_o,       // channel processing
	output reg         error_o       // bad header or stream context length seen
);

	////////////////////////////////////////////////////////////////////
	// registers

	reg [31:0] ctrl_reg;
	reg [31:0] fetch_reg;
	reg        fetch_go_reg;
	reg [31:0] last_hdr_reg;
	reg [2:0]  bc_latched_reg;
	reg        bc_latched_vld_reg;
	reg [31:0] sc_count_reg;
	reg        done_reg;

	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire adr_ok = (wb_adr_i == `CDD_REG_CTRL) | (wb_adr_i == `CDD_REG_FETCH) |
		(wb_adr_i == `CDD_REG_STATUS) | (wb_adr_i == `CDD_REG_MODE) |
		(wb_adr_i == `CDD_REG_LASTHDR) | (wb_adr_i == `CDD_REG_SIDELOAD);
	reg err_reg;
	assign wb_err_o = err_reg;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					merge[b*8 +: 8] = nw[b*8 +: 8];
				end
			end
		end
	endfunction

	wire wr_ctrl  = wb_req & wb_we_i & (wb_adr_i == `CDD_REG_CTRL);
	wire wr_fetch = wb_req & wb_we_i & (wb_adr_i == `CDD_REG_FETCH);
	wire rd_stat  = wb_req & ~wb_we_i & (wb_adr_i == `CDD_REG_STATUS);
	wire fetch_take;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o  <= 1'b0;
			err_reg   <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			ctrl_reg  <= `CDD_CTRL_RESET;
			fetch_reg <= 32'h0000_0000;
			fetch_go_reg <= 1'b0;
			bc_rst_o  <= 1'b0;
			sc_rst_o  <= 1'b0;
		end else begin
			wb_ack_o <= wb_req & adr_ok;
			err_reg  <= wb_req & ~adr_ok;
			bc_rst_o <= 1'b0;
			sc_rst_o <= 1'b0;
			if (wr_ctrl) begin
				ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_0007;
				// unit resets are software's job; nothing clears state on its own
				bc_rst_o <= wb_sel_i[0] & wb_dat_i[`CDD_CTRL_RESET_BC];
				sc_rst_o <= wb_sel_i[0] & wb_dat_i[`CDD_CTRL_RESET_SC];
			end
			if (wr_fetch & ~busy_o) begin
				fetch_reg    <= merge(fetch_reg, wb_dat_i, wb_sel_i);
				fetch_go_reg <= 1'b1;
			end else if (fetch_take) begin
				fetch_go_reg <= 1'b0;
			end
			case (wb_adr_i)
				`CDD_REG_CTRL:     wb_dat_o <= ctrl_reg;
				`CDD_REG_FETCH:    wb_dat_o <= fetch_reg;
				`CDD_REG_STATUS:   wb_dat_o <= {28'h0, done_reg, bc_latched_vld_reg,
					error_o, busy_o};
				`CDD_REG_MODE:     wb_dat_o <= {25'h0, bc_latched_reg, sc_ctl_o};
				`CDD_REG_LASTHDR:  wb_dat_o <= last_hdr_reg;
				`CDD_REG_SIDELOAD: wb_dat_o <= sc_count_reg;
				default:           wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// descriptor fetch

	localparam S_IDLE  = 3'd0;
	localparam S_READ  = 3'd1;
	localparam S_WAIT  = 3'd2;
	localparam S_DEC   = 3'd3;
	localparam S_LOAD  = 3'd4;
	localparam S_XFER  = 3'd5;
	localparam S_NEXT  = 3'd6;

	reg [2:0]  state_reg;
	reg [4:0]  word_reg;
	reg [31:0] base_reg;
	reg [2:0]  slot_reg;
	reg        st_we;
	reg [3:0]  st_ra;
	wire [31:0] st_rd;
	reg [1:0]  rd_phase_reg;
	reg [31:0] len_hold_reg;

	assign fetch_take = (state_reg == S_IDLE) & fetch_go_reg;

	descriptor_word_store #(.AW(4), .DW(32)) descriptor_word_store_inst (
		.clk_i   (clk_i),
		.we_i    (st_we),
		.waddr_i (word_reg[3:0]),
		.wdata_i (mem_dat_i),
		.raddr_i (st_ra),
		.rdata_o (st_rd)
	);

	// fields decode straight from the held header word
	wire [7:0]  unit_sel = last_hdr_reg[31:24];
	wire [3:0]  bc_nib   = last_hdr_reg[23:20];
	wire [3:0]  dtype    = last_hdr_reg[7:4];
	wire is_sc_key = last_hdr_reg == `CDD_HDR_SC_KEY;
	wire is_sc_ctx = last_hdr_reg == `CDD_HDR_SC_CTX;
	wire is_sc_res = last_hdr_reg == `CDD_HDR_SC_RES;
	wire is_sc_rd  = last_hdr_reg == `CDD_HDR_SC_RES_DUMP;
	// stream variants are matched whole; its mode bits name no crypto mode
	wire sc_ok = is_sc_key | is_sc_ctx | is_sc_res | is_sc_rd;
	wire bc_ok = (unit_sel == `CDD_UNIT_BC) & (dtype == `CDD_TYPE_COMMON) &
		(last_hdr_reg[19:8] == 12'h000) & (last_hdr_reg[3:0] == 4'h0) &
		~bc_nib[3] & (bc_nib[2:0] != 3'b111);
	wire sc_unit = unit_sel == `CDD_UNIT_SC;

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg      <= S_IDLE;
			word_reg       <= 5'd0;
			base_reg       <= 32'h0000_0000;
			slot_reg       <= 3'd0;
			rd_phase_reg   <= 2'd0;
			len_hold_reg   <= 32'h0000_0000;
			mem_req_o      <= 1'b0;
			mem_adr_o      <= 32'h0000_0000;
			xfer_valid_o   <= 1'b0;
			xfer_slot_o    <= 3'd0;
			xfer_len_o     <= 32'h0000_0000;
			xfer_ptr_o     <= 32'h0000_0000;
			xfer_unit_o    <= 1'b0;
			sc_ctl_o       <= 4'h0;
			bc_mode_o      <= 3'd0;
			bc_latched_reg <= 3'd0;
			bc_latched_vld_reg <= 1'b0;
			bc_key_keep_o  <= 1'b0;
			sc_keep_o      <= 1'b0;
			sc_count_reg   <= 32'h0000_0000;
			last_hdr_reg   <= 32'h0000_0000;
			busy_o         <= 1'b0;
			error_o        <= 1'b0;
			done_reg       <= 1'b0;
		end else begin
			sc_keep_o     <= ctrl_reg[`CDD_CTRL_STATIC_SC];
			bc_key_keep_o <= ctrl_reg[`CDD_CTRL_STATIC_BC];
			if (bc_rst_o) begin
				bc_latched_vld_reg <= 1'b0;
			end
			if (rd_stat) begin
				done_reg <= 1'b0;
			end
			case (state_reg)
				S_IDLE: begin
					if (fetch_go_reg) begin
						base_reg  <= fetch_reg;
						word_reg  <= 5'd0;
						busy_o    <= 1'b1;
						error_o   <= 1'b0;
						state_reg <= S_READ;
					end
				end
				// header, seven len/ptr pairs, then the next-descriptor word
				S_READ: begin
					mem_req_o <= 1'b1;
					mem_adr_o <= base_reg + {25'h0, word_reg, 2'b00};
					state_reg <= S_WAIT;
				end
				S_WAIT: begin
					if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						if (word_reg == 5'd0) begin
							last_hdr_reg <= mem_dat_i;
						end
						if (word_reg == `CDD_WORDS - 5'd1) begin
							base_reg  <= mem_dat_i;
							state_reg <= S_DEC;
						end else begin
							word_reg  <= word_reg + 5'd1;
							state_reg <= S_READ;
						end
					end
				end
				S_DEC: begin
					slot_reg     <= 3'd0;
					rd_phase_reg <= 2'd0;
					if (sc_unit & sc_ok) begin
						// permute, context in, context out, cipher
						sc_ctl_o <= {is_sc_key, is_sc_ctx, is_sc_key | is_sc_ctx |
							is_sc_rd, 1'b1};
						xfer_unit_o <= 1'b0;
						state_reg   <= S_LOAD;
					end else if (bc_ok) begin
						// static unit keeps the mode taken at first context load
						if (~ctrl_reg[`CDD_CTRL_STATIC_BC] | ~bc_latched_vld_reg) begin
							bc_mode_o <= {bc_nib[`CDD_BC_MODE_CHAIN],
								bc_nib[`CDD_BC_MODE_TRIPLE],
								bc_nib[`CDD_BC_MODE_ENC]};
							bc_latched_reg <= bc_nib[2:0];
							bc_latched_vld_reg <= ctrl_reg[`CDD_CTRL_STATIC_BC];
						end else begin
							bc_mode_o <= bc_latched_reg;
						end
						xfer_unit_o <= 1'b1;
						state_reg   <= S_LOAD;
					end else begin
						error_o   <= 1'b1;
						state_reg <= S_NEXT;
					end
				end
				// two store reads per slot: length then pointer
				S_LOAD: begin
					rd_phase_reg <= rd_phase_reg + 2'd1;
					if (rd_phase_reg == 2'd0) begin
						slot_reg <= slot_reg + 3'd1;
					end else if (rd_phase_reg == 2'd2) begin
						len_hold_reg <= st_rd;
					end else if (rd_phase_reg == 2'd3) begin
						rd_phase_reg <= 2'd0;
						if (len_hold_reg != 32'h0000_0000) begin
							// a short stream context would leave the unit half loaded
							if (~xfer_unit_o & ((slot_reg == 3'd2) | (slot_reg == 3'd6)) &
								(len_hold_reg != `CDD_SC_CTX_LEN)) begin
								error_o <= 1'b1;
							end
							xfer_valid_o <= 1'b1;
							xfer_slot_o  <= slot_reg;
							xfer_len_o   <= len_hold_reg;
							xfer_ptr_o   <= st_rd;
							if (~xfer_unit_o) begin
								sc_count_reg <= sc_count_reg + 32'h1;
							end
							state_reg <= S_XFER;
						end else if (slot_reg == `CDD_PAIRS) begin
							state_reg <= S_NEXT;
						end
					end
				end
				S_XFER: begin
					if (xfer_ready_i) begin
						xfer_valid_o <= 1'b0;
						state_reg    <= (slot_reg == `CDD_PAIRS) ? S_NEXT : S_LOAD;
					end
				end
				S_NEXT: begin
					done_reg <= 1'b1;
					// a cleared next word ends the chain
					if (ctrl_reg[`CDD_CTRL_CHAIN] & (base_reg != 32'h0000_0000)) begin
						word_reg  <= 5'd0;
						state_reg <= S_READ;
					end else begin
						busy_o    <= 1'b0;
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// read index: phase 1 presents length word, phase 2 pointer word
	always @* begin
		st_we = (state_reg == S_WAIT) & mem_ack_i;
		st_ra = {slot_reg, 1'b0} - {3'b000, rd_phase_reg[0]};
	end

endmodule // cipher_descriptor_decode

`default_nettype wire

// [cipher_descriptor_decode_props.sv]
`timescale 1ns/1ps
`default_nettype none
module decode_props (
	input wire logic        clk_i,        // clock
	input wire logic        rst_i,        // reset
	input wire logic        wb_cyc_i,     // cycle
	input wire logic        wb_stb_i,     // strobe
	input wire logic        wb_ack_o,     // ack
	input wire logic        wb_err_o,     // err
	input wire logic        mem_req_o,    // read req
	input wire logic [31:0] mem_adr_o,    // read addr
	input wire logic        mem_ack_i,    // read ack
	input wire logic        xfer_valid_o, // cmd valid
	input wire logic        xfer_ready_i, // cmd done
	input wire logic [2:0]  xfer_slot_o,  // pair index
	input wire logic [31:0] xfer_len_o,   // length
	input wire logic [31:0] xfer_ptr_o,   // pointer
	input wire logic        xfer_unit_o,  // unit
	input wire logic [3:0]  sc_ctl_o,     // stream ctl
	input wire logic [2:0]  bc_mode_o,    // block mode
	input wire logic        busy_o        // busy
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	a_ack_single: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
		else $error("ack held too long");
	a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
		|=> wb_ack_o || wb_err_o) else $error("bus request unanswered");
	a_mem_hold: assert property (mem_req_o && !mem_ack_i
		|=> mem_req_o && $stable(mem_adr_o))
		else $error("memory request dropped");
	a_xfer_hold: assert property (xfer_valid_o && !xfer_ready_i
		|=> xfer_valid_o && $stable({xfer_slot_o, xfer_len_o, xfer_ptr_o}))
		else $error("transfer command changed");
	a_skip_empty: assert property (xfer_valid_o
		|-> xfer_len_o != 0 && xfer_slot_o != 0)
		else $error("empty transfer issued");
	a_mode_legal: assert property (xfer_valid_o && xfer_unit_o
		|-> bc_mode_o != 3'h7)
		else $error("rejected block mode used");
	a_unload_after: assert property (xfer_valid_o && !xfer_unit_o
		&& sc_ctl_o[1] |-> sc_ctl_o[0])
		else $error("unload without cipher");
	a_busy_cover: assert property (xfer_valid_o || mem_req_o |-> busy_o)
		else $error("work while idle");
endmodule // decode_props
bind cipher_descriptor_decode decode_props decode_props_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.mem_req_o(mem_req_o), .mem_adr_o(mem_adr_o), .mem_ack_i(mem_ack_i),
	.xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i), .xfer_slot_o(xfer_slot_o),
	.xfer_len_o(xfer_len_o), .xfer_ptr_o(xfer_ptr_o), .xfer_unit_o(xfer_unit_o),
	.sc_ctl_o(sc_ctl_o), .bc_mode_o(bc_mode_o), .busy_o(busy_o));
`default_nettype wire

// [memory_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
module memory_side_model (
	input wire logic        clk_i,        // clock
	input wire logic        mem_req_o,    // read req
	input wire logic [31:0] mem_adr_o,    // byte addr
	output var logic        mem_ack_i,    // read ack
	output var logic [31:0] mem_dat_i,    // read data
	input wire logic        xfer_valid_o, // cmd valid
	output var logic        xfer_ready_i  // cmd done
);
	logic [31:0] words [16];
	initial begin
		mem_ack_i = 1'b0;
		mem_dat_i = 32'h0;
		xfer_ready_i = 1'b0;
	end
	// random latency; data line churns when not answering
	always @(posedge clk_i) begin
		mem_ack_i <= 1'b0;
		xfer_ready_i <= 1'b0;
		mem_dat_i <= ~mem_dat_i;
		if (mem_req_o && !mem_ack_i && $urandom_range(0, 2) == 0) begin
			mem_ack_i <= 1'b1;
			mem_dat_i <= words[mem_adr_o[5:2]]; // byte address, word index
		end
		if (xfer_valid_o && !xfer_ready_i && $urandom_range(0, 3) == 0)
			xfer_ready_i <= 1'b1;
	end
endmodule // memory_side_model
`default_nettype wire

// [test_cipher_descriptor_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module test_cipher_descriptor_decode;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 0;
	logic [31:0] dat = 0, wb_dat_o, mem_adr_o, mem_dat_i, xfer_len_o, xfer_ptr_o;
	logic wb_ack_o, wb_err_o, mem_req_o, mem_ack_i, xfer_valid_o, xfer_ready_i, xfer_unit_o;
	logic bc_key_keep_o, sc_keep_o, bc_rst_o, sc_rst_o, busy_o, error_o;
	logic [2:0] xfer_slot_o, bc_mode_o;
	logic [3:0] sc_ctl_o;
	logic [71:0] xq[$], rq[$];
	int miscompares = 0, checks_done = 0;
	logic [31:0] hdrs [11] = '{32'h10200050, 32'h10700050, 32'h10100050, 32'h10300050,
		32'h20500010, 32'h20600010, 32'h20100010, 32'h20000010, 32'h20300010, 32'h20200010,
		32'h20400010};
	logic [1:0] rst_seen = 0;
	logic [3:0] ctls [4] = '{4'b1011, 4'b0111, 4'b0001, 4'b0011};
	logic [6:0] masks [4] = '{7'h3c, 7'h3a, 7'h18, 7'h38};
	initial forever #12.5 clk_i = ~clk_i;
	cipher_descriptor_decode cipher_descriptor_decode_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.mem_req_o(mem_req_o), .mem_adr_o(mem_adr_o), .mem_ack_i(mem_ack_i),
		.mem_dat_i(mem_dat_i), .xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i),
		.xfer_slot_o(xfer_slot_o), .xfer_len_o(xfer_len_o), .xfer_ptr_o(xfer_ptr_o),
		.xfer_unit_o(xfer_unit_o), .sc_ctl_o(sc_ctl_o), .bc_mode_o(bc_mode_o),
		.bc_key_keep_o(bc_key_keep_o), .sc_keep_o(sc_keep_o), .bc_rst_o(bc_rst_o),
		.sc_rst_o(sc_rst_o), .busy_o(busy_o), .error_o(error_o));
	memory_side_model memory_side_model_inst (.clk_i(clk_i), .mem_req_o(mem_req_o),
		.mem_adr_o(mem_adr_o), .mem_ack_i(mem_ack_i), .mem_dat_i(mem_dat_i),
		.xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [71:0] got, input logic [71:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		do @(posedge clk_i); while (!(wb_ack_o || wb_err_o) && ++n < 50);
		cyc <= 1'b0; stb <= 1'b0;
		if (n >= 50)
			miscompares++;
	endtask
	// one descriptor at word 0; x is the expected unit programming
	task automatic run(input logic [31:0] h, input logic [6:0] m, input logic [3:0] x);
		logic [31:0] l, p, d;
		int n = 0;
		memory_side_model_inst.words[0] = h;
		memory_side_model_inst.words[15] = 32'h0;
		for (int s = 1; s < 8; s++) begin
			// lengths as a well-behaved host fills the slots
			case (s)
				2: l = h[29] ? 32'h8 : 32'h103;
				3: l = !h[29] ? 32'($urandom_range(5, 16)) :
					h[21] ? 32'h10 + 32'($urandom_range(0, 1)) * 32'h8 : 32'h8;
				4: begin
					d = 32'($urandom_range(1, 64)) << 3;
					l = d;
				end
				5: l = d;
				6: l = 32'h103;
				default: l = 32'h4;
			endcase
			if (!m[s-1])
				l = 32'h0;
			p = $urandom;
			memory_side_model_inst.words[2*s-1] = l;
			memory_side_model_inst.words[2*s] = p;
			if (l != 0 && h != 32'h20700010)
				xq.push_back({h[29], 3'(s), l, p, x});
		end
		wb(1'b1, 8'h04, 32'h0);
		repeat (2) @(posedge clk_i);
		while (busy_o !== 1'b0 && ++n < 3000) @(posedge clk_i);
		if (n >= 3000)
			miscompares++;
		check(72'(xq.size()), 72'h0);
		check(72'(error_o), 72'(h == 32'h20700010));
		rq.push_back({40'h0, h});
		wb(1'b0, 8'h10, 32'h0);
		$display("test %h done", h);
	endtask
	always @(posedge clk_i) begin
		if (!rst_i)
			rst_seen <= rst_seen | {bc_rst_o, sc_rst_o};
		if (xfer_valid_o && xfer_ready_i)
			check({xfer_unit_o, xfer_slot_o, xfer_len_o, xfer_ptr_o,
				xfer_unit_o ? {1'b0, bc_mode_o} : sc_ctl_o}, xq.pop_front());
		if ((wb_ack_o || wb_err_o) && !we)
			check({wb_err_o, wb_err_o ? 32'h0 : wb_dat_o}, rq.pop_front());
	end
	initial begin
		#(25 * 60000);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hd6c8409b));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 11; i++)
			run(hdrs[i], i < 4 ? masks[i] : 7'h1e,
				i < 4 ? ctls[i] : {1'b0, hdrs[i][22:20]});
		wb(1'b1, 8'h00, 32'h7);
		repeat (2) @(posedge clk_i);
		check(72'({sc_keep_o, bc_key_keep_o}), 72'h3);
		run(32'h20500010, 7'h1e, 4'h5);
		run(32'h20100010, 7'h18, 4'h5);
		run(32'h20700010, 7'h18, 4'h0);
		rq.push_back({39'h0, 1'b1, 32'h0});
		wb(1'b0, 8'h20, 32'h0);
		// units are reset by hand before static use is dropped
		wb(1'b1, 8'h00, 32'h1f);
		rq.push_back(72'h0a);
		wb(1'b0, 8'h08, 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		repeat (2) @(posedge clk_i);
		check(72'({rst_seen, sc_keep_o, bc_key_keep_o}), 72'hc);
		tally_and_finish();
	end
endmodule // test_cipher_descriptor_decode
`default_nettype wire
